// File: core/rx_status_pkg.sv
// Constants, register map and types for the receive status block
package rx_status_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned WATCHDOG_BYTES = 2048;
  localparam int unsigned RUNT_BYTES = 64;
  localparam int unsigned MAX_FRAME_BYTES = 1518;
  localparam int unsigned TYPE_THRESHOLD = 1500;
  localparam int unsigned TYPE_MIN_BYTES = 14;
  localparam int unsigned LEN_W = 14;
  localparam int unsigned DRIB_NIBBLE = 4;
  localparam int unsigned DRIB_10M = 3;
  // Status word field positions
  localparam int unsigned B_FILTER_FAIL = 30;
  localparam int unsigned B_LEN_HI = 29;
  localparam int unsigned B_LEN_LO = 16;
  localparam int unsigned B_ERR_SUM = 15;
  localparam int unsigned B_BCAST = 13;
  localparam int unsigned B_LEN_MISMATCH = 12;
  localparam int unsigned B_RUNT = 11;
  localparam int unsigned B_MCAST = 10;
  localparam int unsigned B_TOO_LONG = 7;
  localparam int unsigned B_LATE_COL = 6;
  localparam int unsigned B_FRAME_TYPE = 5;
  localparam int unsigned B_WATCHDOG = 4;
  localparam int unsigned B_MII_ERR = 3;
  localparam int unsigned B_DRIBBLE = 2;
  localparam int unsigned B_CRC_ERR = 1;
  // Register byte addresses on the word-aligned bus
  localparam logic [3:0] ADDR_MAC_CTRL = 4'h0;
  localparam logic [3:0] ADDR_RX_STAT = 4'h4;
  localparam logic [3:0] ADDR_LAST_WORD = 4'h8;
  localparam logic [3:0] ADDR_ERR_CLR = 4'hC;
  localparam int unsigned CTRL_RX_EN = 2;
  localparam int unsigned CTRL_PASS_BAD = 16;
  localparam int unsigned STAT_RX_ERR = 0;
  localparam int unsigned STAT_HALTED = 1;
  localparam int unsigned STAT_BUSY = 2;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] CTRL_MASK = 32'h0001_0004;
  typedef enum logic [1:0] {
    RX_IDLE, RX_FRAME, RX_HALTED
  } rx_state_t;
endpackage : rx_status_pkg

// File: core/flag_if.sv
// Event and flag group passed between the receive core and its flag latch
`timescale 1ns/1ps
interface flag_if;
  logic set;
  logic clear;
  logic flag;
  modport owner (input set, input clear, output flag);
  modport user (output set, output clear, input flag);
endinterface : flag_if

// File: core/sticky_flag.sv
// Sticky flag whose set wins over a clear in the same cycle
`timescale 1ns/1ps
module sticky_flag (
  input wire logic clk_in,
  input wire logic rst_in,
  flag_if.owner port
);
  // Set has priority so a coincident event is never lost
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      port.flag <= 1'b0;
    end else if (port.set) begin
      port.flag <= 1'b1;
    end else if (port.clear) begin
      port.flag <= 1'b0;
    end
  end
endmodule : sticky_flag

// File: core/rx_status_word.sv
// Receive status word builder, receiver stop control and error flag
//
// Implementation choices: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ps
module rx_status_word (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [3:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic soft_reset_in,
  input wire logic frame_start_in,
  input wire logic byte_valid_in,
  input wire logic frame_end_in,
  input wire logic rx_er_in,
  input wire logic collision_in,
  input wire logic crc_bad_in,
  input wire logic filter_fail_in,
  input wire logic bcast_in,
  input wire logic mcast_in,
  input wire logic [15:0] len_type_in,
  input wire logic [2:0] extra_bits_in,
  input wire logic nibble_mode_in,
  input wire logic data_underrun_in,
  input wire logic status_underrun_in,
  input wire logic status_fifo_full_in,
  output logic [31:0] status_word_out,
  output logic status_push_out,
  output logic frame_drop_out,
  output logic receive_enable_out,
  output logic receiver_halted_event_out,
  output logic receiver_error_flag_out
);
  import rx_status_pkg::*;

  localparam logic [LEN_W-1:0] RUNT_LIM = LEN_W'(RUNT_BYTES);
  localparam logic [LEN_W-1:0] LONG_LIM = LEN_W'(MAX_FRAME_BYTES);
  localparam logic [LEN_W-1:0] WDOG_LIM = LEN_W'(WATCHDOG_BYTES);
  localparam logic [LEN_W-1:0] TYPE_MIN = LEN_W'(TYPE_MIN_BYTES);
  localparam logic [LEN_W-1:0] LEN_MAX = {LEN_W{1'b1}};
  localparam logic [15:0] TYPE_LIM = 16'(TYPE_THRESHOLD);
  localparam logic [2:0] DRIB_NIB = 3'(DRIB_NIBBLE);
  localparam logic [2:0] DRIB_TEN = 3'(DRIB_10M);

  rx_state_t state;
  logic [31:0] mac_control_reg;
  logic [LEN_W-1:0] byte_count;
  logic saw_rx_er;
  logic saw_late_col;
  logic [31:0] next_word;
  logic wdog_hit;
  logic runt;
  logic too_long;
  logic late_col;
  logic crc_err;
  logic frame_type;
  logic length_mismatch;
  logic dribble;
  logic error_summary;
  logic [LEN_W-1:0] final_len;
  logic rd_pending;
  logic wr_err_clr;
  flag_if err_flag ();

  assign receive_enable_out = mac_control_reg[CTRL_RX_EN];

  // Single-cycle wait state on reads keeps read data registered
  assign avs_waitrequest_out = avs_read_in & ~rd_pending;
  assign wr_err_clr = avs_write_in & (avs_address_in == ADDR_ERR_CLR)
                      & avs_byteenable_in[0] & avs_writedata_in[STAT_RX_ERR];

  // Control register: only enable and pass-bad bits are storable
  always_ff @(posedge clk_in) begin
    if (rst_in | soft_reset_in) begin
      mac_control_reg <= CTRL_RESET;
    end else if (avs_write_in & (avs_address_in == ADDR_MAC_CTRL)) begin
      for (int i = 0; i < 4; i++) begin
        if (avs_byteenable_in[i]) begin
          mac_control_reg[i*8 +: 8] <=
            avs_writedata_in[i*8 +: 8] & CTRL_MASK[i*8 +: 8];
        end
      end
    end
  end

  // Read path; unmapped addresses answer zero
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rd_pending <= 1'b0;
      avs_readdata_out <= 32'h0000_0000;
    end else begin
      rd_pending <= avs_read_in & ~rd_pending;
      if (avs_read_in & ~rd_pending) begin
        case (avs_address_in)
          ADDR_MAC_CTRL: avs_readdata_out <= mac_control_reg;
          ADDR_RX_STAT: begin
            avs_readdata_out <= 32'h0000_0000;
            avs_readdata_out[STAT_RX_ERR] <= err_flag.flag;
            avs_readdata_out[STAT_HALTED] <= (state == RX_HALTED);
            avs_readdata_out[STAT_BUSY] <= (state == RX_FRAME);
          end
          ADDR_LAST_WORD: avs_readdata_out <= status_word_out;
          default: avs_readdata_out <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Receive state: a frame in flight finishes before the halt
  always_ff @(posedge clk_in) begin
    if (rst_in | soft_reset_in) begin
      state <= RX_HALTED;
    end else begin
      case (state)
        RX_IDLE: begin
          if (!receive_enable_out) begin
            state <= RX_HALTED;
          end else if (frame_start_in) begin
            state <= RX_FRAME;
          end
        end
        RX_FRAME: begin
          if (frame_end_in) begin
            state <= receive_enable_out ? RX_IDLE : RX_HALTED;
          end
        end
        RX_HALTED: begin
          if (receive_enable_out) begin
            state <= RX_IDLE;
          end
        end
        default: state <= RX_HALTED;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in | soft_reset_in) begin
      receiver_halted_event_out <= 1'b0;
    end else begin
      receiver_halted_event_out <= (state != RX_HALTED) & !receive_enable_out
        & ((state == RX_IDLE) | ((state == RX_FRAME) & frame_end_in));
    end
  end

  // count full frame, saturating rather than truncating reception
  always_ff @(posedge clk_in) begin
    if (rst_in | (frame_start_in & (state == RX_IDLE))) begin
      byte_count <= '0;
    end else if ((state == RX_FRAME) & byte_valid_in & byte_count != LEN_MAX)
    begin
      byte_count <= byte_count + LEN_W'(1);
    end
  end

  // receive error seen anywhere in the frame, also late collision
  always_ff @(posedge clk_in) begin
    if (rst_in | (frame_start_in & (state == RX_IDLE))) begin
      saw_rx_er <= 1'b0;
      saw_late_col <= 1'b0;
    end else if (state == RX_FRAME) begin
      if (rx_er_in) begin
        saw_rx_er <= 1'b1;
      end
      if (collision_in & (byte_count >= RUNT_LIM)) begin
        saw_late_col <= 1'b1;
      end
    end
  end

  // Final flags include the byte arriving with the end strobe
  always_comb begin
    final_len = byte_count;
    if (byte_valid_in & byte_count != LEN_MAX) begin
      final_len = byte_count + LEN_W'(1);
    end
    late_col = saw_late_col | (collision_in & (byte_count >= RUNT_LIM));
    runt = final_len < RUNT_LIM;
    too_long = final_len > LONG_LIM;
    wdog_hit = final_len > WDOG_LIM;
    crc_err = crc_bad_in | saw_rx_er | rx_er_in;
    // type frame, not for tiny runts
    frame_type = (len_type_in > TYPE_LIM) & (final_len >= TYPE_MIN);
    length_mismatch = (len_type_in <= TYPE_LIM) & (final_len >= TYPE_MIN)
                      & (16'(final_len) != len_type_in);
    dribble = !late_col & (nibble_mode_in ? (extra_bits_in == DRIB_NIB)
                                          : (extra_bits_in >= DRIB_TEN));
    // summary of the four error bits
    error_summary = runt | too_long | late_col | crc_err;
    next_word = 32'h0000_0000;
    next_word[B_FILTER_FAIL] = filter_fail_in;
    next_word[B_LEN_HI:B_LEN_LO] = final_len;
    next_word[B_ERR_SUM] = error_summary;
    next_word[B_BCAST] = bcast_in;
    next_word[B_LEN_MISMATCH] = length_mismatch;
    next_word[B_RUNT] = runt;
    next_word[B_MCAST] = mcast_in;
    next_word[B_TOO_LONG] = too_long;
    next_word[B_LATE_COL] = late_col;
    next_word[B_FRAME_TYPE] = frame_type;
    next_word[B_WATCHDOG] = wdog_hit;
    next_word[B_MII_ERR] = saw_rx_er | rx_er_in;
    next_word[B_DRIBBLE] = dribble;
    next_word[B_CRC_ERR] = crc_err;
  end

  // latch whole word, push after last data byte, or drop it instead for a runt while pass-bad is clear
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      status_word_out <= 32'h0000_0000;
      status_push_out <= 1'b0;
      frame_drop_out <= 1'b0;
    end else begin
      status_push_out <= 1'b0;
      frame_drop_out <= 1'b0;
      if ((state == RX_FRAME) & frame_end_in) begin
        status_word_out <= next_word;
        if (runt & !mac_control_reg[CTRL_PASS_BAD]) begin
          frame_drop_out <= 1'b1;
        end else begin
          status_push_out <= 1'b1;
        end
      end
    end
  end

  // underrun or status overrun raises the error flag
  assign err_flag.set = data_underrun_in | status_underrun_in
    | (status_fifo_full_in & status_push_out);
  // only reset, soft reset or software write clears it
  assign err_flag.clear = soft_reset_in | wr_err_clr;
  assign receiver_error_flag_out = err_flag.flag;

  sticky_flag u_err_flag (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .port(err_flag)
  );

  // Status word checks in the cycle the push stands, the runt-drop check also on a drop; the reserved-bit check runs every cycle
  a_summary_or: assert property (
    @(posedge clk_in) disable iff (rst_in)
    status_push_out |-> status_word_out[B_ERR_SUM] ==
      (status_word_out[B_RUNT] | status_word_out[B_TOO_LONG]
       | status_word_out[B_LATE_COL] | status_word_out[B_CRC_ERR]))
    else $error("error summary mismatch");
  a_reserved_zero: assert property (
    @(posedge clk_in) disable iff (rst_in)
    (status_word_out & 32'h8000_4301) == 32'h0000_0000)
    else $error("reserved status bits set");
  a_runt_drop: assert property (
    @(posedge clk_in) disable iff (rst_in)
    (status_push_out | frame_drop_out) |->
      (frame_drop_out == (status_word_out[B_RUNT]
                          & !mac_control_reg[CTRL_PASS_BAD])))
    else $error("runt delivery wrong");
  a_runt_len: assert property (
    @(posedge clk_in) disable iff (rst_in)
    status_push_out |-> status_word_out[B_RUNT] ==
      (status_word_out[B_LEN_HI:B_LEN_LO] < RUNT_LIM))
    else $error("runt flag wrong");
  a_dribble_col: assert property (
    @(posedge clk_in) disable iff (rst_in)
    status_push_out |-> !(status_word_out[B_DRIBBLE]
                          & status_word_out[B_LATE_COL]))
    else $error("dribble with late collision");
  a_crc_rxer: assert property (
    @(posedge clk_in) disable iff (rst_in)
    status_push_out & status_word_out[B_MII_ERR] |->
      status_word_out[B_CRC_ERR])
    else $error("crc not set on rx error");
  a_long_flag: assert property (
    @(posedge clk_in) disable iff (rst_in)
    status_push_out |-> status_word_out[B_TOO_LONG] ==
      (status_word_out[B_LEN_HI:B_LEN_LO] > LONG_LIM))
    else $error("too long flag wrong");
  a_wdog_flag: assert property (
    @(posedge clk_in) disable iff (rst_in)
    status_push_out |-> status_word_out[B_WATCHDOG] ==
      (status_word_out[B_LEN_HI:B_LEN_LO] > WDOG_LIM))
    else $error("watchdog flag wrong");
  a_type_runt: assert property (
    @(posedge clk_in) disable iff (rst_in)
    status_push_out & (status_word_out[B_LEN_HI:B_LEN_LO] < TYPE_MIN)
      |-> !status_word_out[B_FRAME_TYPE])
    else $error("type flag on tiny frame");
  // Halt pulse: one cycle, and only once reception has really stopped
  sequence s_stop_seen;
    (state == RX_FRAME) & frame_end_in & !receive_enable_out;
  endsequence
  sequence s_idle_stop;
    (state == RX_IDLE) & !receive_enable_out;
  endsequence
  sequence s_halt_once;
    receiver_halted_event_out ##1 !receiver_halted_event_out;
  endsequence
  a_halt_pulse: assert property (
    @(posedge clk_in) disable iff (rst_in | soft_reset_in)
    s_stop_seen |=> s_halt_once)
    else $error("halt pulse missing");
  a_halt_idle: assert property (
    @(posedge clk_in) disable iff (rst_in | soft_reset_in)
    s_idle_stop |=> s_halt_once)
    else $error("idle halt pulse missing");
  a_halt_state: assert property (
    @(posedge clk_in) disable iff (rst_in)
    receiver_halted_event_out |-> (state == RX_HALTED))
    else $error("halt pulse while receiving");
  // Error flag sources, and the flag must not stall reception
  a_error_set: assert property (
    @(posedge clk_in) disable iff (rst_in)
    data_underrun_in | status_underrun_in |=> receiver_error_flag_out)
    else $error("receiver error not raised");
  a_overrun_set: assert property (
    @(posedge clk_in) disable iff (rst_in)
    status_fifo_full_in & status_push_out |=> receiver_error_flag_out)
    else $error("status overrun not flagged");
  a_keep_running: assert property (
    @(posedge clk_in) disable iff (rst_in | soft_reset_in)
    receiver_error_flag_out & (state == RX_IDLE) & receive_enable_out
      & frame_start_in |=> (state == RX_FRAME))
    else $error("receiver stopped by error flag");
endmodule : rx_status_word

// File: testbench/rx_frame_src.sv
// Stand-in for the MAC receive path that feeds bytes and frame flags
`timescale 1ns/1ps
module rx_frame_src (
  input wire logic clk_in,
  output logic start_out,
  output logic byte_out,
  output logic end_out,
  output logic rx_er_out,
  output logic col_out,
  output logic [15:0] lt_out,
  output logic [2:0] xb_out,
  output logic [4:0] fl_out
);
  // Quiet lines at time zero
  initial begin
    {start_out, byte_out, end_out, rx_er_out, col_out} = 5'h0;
    lt_out = 16'h0;
    xb_out = 3'h0;
    fl_out = 5'h0;
  end
  // One byte a cycle; end-of-frame fields hold inverted values until the
  // closing byte, so a design that samples them early sees wrong data
  task automatic send(input int len, input logic [15:0] lt,
      input logic [2:0] xb, input logic [6:0] f);
    @(posedge clk_in);
    start_out <= 1'b1;
    lt_out <= ~lt;
    xb_out <= ~xb;
    fl_out <= ~f[6:2];
    for (int i = 1; i <= len; i++) begin
      @(posedge clk_in);
      start_out <= 1'b0;
      byte_out <= 1'b1;
      rx_er_out <= f[0] && i == 5;
      col_out <= f[1] && i == len;
      end_out <= i == len;
      if (i == len) begin
        lt_out <= lt;
        xb_out <= xb;
        fl_out <= f[6:2];
      end
    end
    @(posedge clk_in);
    {byte_out, end_out, rx_er_out, col_out} <= 4'h0;
    lt_out <= ~lt;
    fl_out <= ~f[6:2];
  endtask : send
endmodule : rx_frame_src

// File: testbench/rx_status_word_tb_top.sv
// Self-checking bench for the receive status word block
`timescale 1ns/1ps
module rx_status_word_tb_top;
  import rx_status_pkg::*;
  logic clk_in, rst_in, avs_read, avs_write, soft_reset, fifo_full;
  logic [3:0] avs_address, avs_be;
  logic [31:0] avs_wdata, rdata, seed, last_e, rd_data, word;
  logic [1:0] upr;
  logic st, bv, fe, rer, col, wait_req, push, drop, en, halt_ev, err;
  logic [15:0] lt;
  logic [2:0] xb;
  logic [4:0] fl;
  int err_count, n_compared, cycles, halt_cnt, h;
  // Boundary frame lengths around each size limit
  int b_len [9] = '{10, 13, 14, 63, 64, 1518, 1519, 2048, 2049};

  rx_status_word u_dut (
    .clk_in(clk_in), .rst_in(rst_in), .avs_address_in(avs_address),
    .avs_read_in(avs_read), .avs_write_in(avs_write),
    .avs_writedata_in(avs_wdata), .avs_byteenable_in(avs_be),
    .avs_readdata_out(rd_data), .avs_waitrequest_out(wait_req),
    .soft_reset_in(soft_reset), .frame_start_in(st), .byte_valid_in(bv),
    .frame_end_in(fe), .rx_er_in(rer), .collision_in(col),
    .crc_bad_in(fl[0]), .filter_fail_in(fl[1]), .bcast_in(fl[2]),
    .mcast_in(fl[3]), .len_type_in(lt), .extra_bits_in(xb),
    .nibble_mode_in(fl[4]), .data_underrun_in(upr[0]),
    .status_underrun_in(upr[1]), .status_fifo_full_in(fifo_full),
    .status_word_out(word), .status_push_out(push),
    .frame_drop_out(drop), .receive_enable_out(en),
    .receiver_halted_event_out(halt_ev), .receiver_error_flag_out(err)
  );
  rx_frame_src u_src (
    .clk_in(clk_in), .start_out(st), .byte_out(bv), .end_out(fe),
    .rx_er_out(rer), .col_out(col), .lt_out(lt), .xb_out(xb), .fl_out(fl)
  );

  // 100 MHz clock
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  // Hang guard; the longest run is well under this many cycles
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 80000) begin
      err_count++;
      close_out();
    end
  end
  // Count halt pulses; non-blocking so readers at the edge see a stable sum
  always @(posedge clk_in) begin
    if (halt_ev === 1'b1) halt_cnt <= halt_cnt + 1;
  end

  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : close_out

  task automatic chk(input string nm, input logic [31:0] e,
      input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      err_count++;
    end
  endtask : chk

  // Avalon transfer, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] a,
      input logic [31:0] d, input logic [3:0] be);
    @(posedge clk_in);
    avs_address <= a;
    avs_wdata <= d;
    avs_be <= be;
    avs_read <= !wr;
    avs_write <= wr;
    // Only the hang guard ends a wait that never sees waitrequest low
    do begin
      @(posedge clk_in);
    end while (wait_req !== 1'b0);
    rdata = rd_data;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task automatic rd(input logic [3:0] a, input logic [31:0] e,
      input string nm);
    bus(1'b0, a, 32'h0, 4'hF);
    chk(nm, e, rdata);
  endtask : rd

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  // f: 0 rx error, 1 late collision, 2 CRC bad, 3 filter fail,
  // 4 broadcast, 5 multicast, 6 nibble mode
  function automatic logic [31:0] exp_word(input int len,
      input logic [15:0] t, input logic [2:0] x, input logic [6:0] f);
    logic [31:0] w;
    w = 32'h0;
    w[B_FILTER_FAIL] = f[3];
    w[B_LEN_HI:B_LEN_LO] = LEN_W'(len);
    w[B_BCAST] = f[4];
    w[B_MCAST] = f[5];
    w[B_RUNT] = len < RUNT_BYTES;
    w[B_TOO_LONG] = len > MAX_FRAME_BYTES;
    w[B_LATE_COL] = f[1];
    w[B_WATCHDOG] = len > WATCHDOG_BYTES;
    w[B_FRAME_TYPE] = t > TYPE_THRESHOLD && len >= TYPE_MIN_BYTES;
    w[B_LEN_MISMATCH] = t <= TYPE_THRESHOLD && len >= TYPE_MIN_BYTES
        && int'(t) != len;
    w[B_MII_ERR] = f[0];
    w[B_DRIBBLE] = !f[1] && (f[6] ? x == DRIB_NIBBLE : x >= DRIB_10M);
    w[B_CRC_ERR] = f[2] | f[0];
    w[B_ERR_SUM] = w[B_RUNT] | w[B_TOO_LONG] | w[B_LATE_COL] | w[B_CRC_ERR];
    return w;
  endfunction : exp_word

  // Host verdict on a pushed frame; CRC means nothing for runts, late
  // collisions and watchdog frames, so the host does not trust it there
  function automatic logic host_ok(input logic [31:0] w);
    logic crc_valid;
    crc_valid = !(w[B_RUNT] | w[B_LATE_COL] | w[B_WATCHDOG]);
    return crc_valid & !w[B_CRC_ERR] & !w[B_TOO_LONG];
  endfunction : host_ok

  // Send one frame and check push or drop and the word it carries
  task automatic frame(input int len, input logic [15:0] t,
      input logic [2:0] x, input logic [6:0] f, input bit pass, input bit on);
    logic p, d, he, hg;
    int n;
    logic [1:0] e;
    p = 1'b0;
    d = 1'b0;
    n = 0;
    e = on ? {len >= RUNT_BYTES || pass, len < RUNT_BYTES && !pass} : 2'h0;
    u_src.send(len, t, x, f);
    while (!p && !d && n < 6) begin
      @(posedge clk_in);
      n++;
      p = push === 1'b1;
      d = drop === 1'b1;
    end
    chk("outcome", {30'h0, e}, {30'h0, p, d});
    last_e = exp_word(len, t, x, f);
    if (p) chk("status word", last_e, word);
    he = host_ok(last_e);
    hg = host_ok(word);
    if (p) chk("host view", {31'h0, he}, {31'h0, hg});
  endtask : frame

  initial begin
    logic [31:0] r;
    int len;
    logic [15:0] t;
    {avs_read, avs_write, soft_reset, fifo_full} = 4'h0;
    avs_address = 4'h0;
    avs_be = 4'hF;
    avs_wdata = 32'h0;
    upr = 2'h0;
    seed = 32'h8913;
    {err_count, n_compared} = {2{32'sd0}};
    rst_in = 1'b1;
    repeat (5) @(posedge clk_in);
    rst_in <= 1'b0;
    rd(ADDR_MAC_CTRL, CTRL_RESET, "ctrl reset");
    chk("enable", 32'h0, {31'h0, en});
    frame(80, 16'h0050, 3'h0, 7'h0, 1'b0, 1'b0);
    bus(1'b1, ADDR_MAC_CTRL, 32'hFFFF_FFFF, 4'hF);
    rd(ADDR_MAC_CTRL, CTRL_MASK, "ctrl mask");
    // Boundary lengths, each with one flag set except the 13-byte frame, which has none
    for (int i = 0; i < 9; i++) begin
      len = b_len[i];
      t = i[0] ? 16'h05DD : 16'h05DC;
      frame(len, t, 3'(i), 7'(1 << (i % 7)) & (len > 99 ? 7'h7F : 7'h7D),
          1'b1, 1'b1);
    end
    rd(ADDR_LAST_WORD, last_e, "last word");
    rd(4'h2, 32'h0, "unmapped");
    bus(1'b1, ADDR_MAC_CTRL, 32'h0000_0004, 4'hF);
    frame(40, 16'h0028, 3'h0, 7'h4, 1'b0, 1'b1);
    bus(1'b1, ADDR_MAC_CTRL, CTRL_MASK, 4'hF);
    for (int k = 0; k < 10; k++) begin
      r = rnd();
      len = 100 + int'(r[10:0]);
      t = r[12] ? 16'(len) : (r[13] ? 16'h0600 | 16'(r[7:0]) : 16'(r[9:0]));
      frame(len, t, r[18:16], r[25:19], 1'b1, 1'b1);
    end
    h = halt_cnt;
    bus(1'b1, ADDR_MAC_CTRL, 32'h0001_0000, 4'hF);
    repeat (4) @(posedge clk_in);
    chk("idle halt", 32'(h + 1), 32'(halt_cnt));
    rd(ADDR_RX_STAT, 32'h2, "halted stat");
    bus(1'b1, ADDR_MAC_CTRL, CTRL_MASK, 4'hF);
    h = halt_cnt;
    fork
      frame(300, 16'h0800, 3'h0, 7'h0, 1'b1, 1'b1);
      begin
        repeat (50) @(posedge clk_in);
        bus(1'b1, ADDR_MAC_CTRL, 32'h0001_0000, 4'hF);
        repeat (3) @(posedge clk_in);
        chk("no halt in frame", 32'(h), 32'(halt_cnt));
      end
    join
    repeat (4) @(posedge clk_in);
    chk("halt after frame", 32'(h + 1), 32'(halt_cnt));
    bus(1'b1, ADDR_MAC_CTRL, CTRL_MASK, 4'hF);
    // Each underrun kind raises the flag, a write of one clears it
    for (int k = 0; k < 2; k++) begin
      @(posedge clk_in);
      upr <= 2'(k + 1);
      @(posedge clk_in);
      upr <= 2'h0;
      rd(ADDR_RX_STAT, 32'h1, "error stat");
      bus(1'b1, ADDR_ERR_CLR, 32'h1, 4'hF);
      @(posedge clk_in);
      chk("error clear", 32'h0, {31'h0, err});
    end
    fifo_full <= 1'b1;
    frame(120, 16'h0078, 3'h0, 7'h0, 1'b1, 1'b1);
    fifo_full <= 1'b0;
    @(posedge clk_in);
    chk("overrun flag", 32'h1, {31'h0, err});
    frame(200, 16'h0800, 3'h4, 7'h40, 1'b1, 1'b1);
    @(posedge clk_in);
    soft_reset <= 1'b1;
    @(posedge clk_in);
    soft_reset <= 1'b0;
    @(posedge clk_in);
    chk("soft reset", 32'h0, {30'h0, err, en});
    close_out();
  end
endmodule : rx_status_word_tb_top
